/* logic/reset_source_sequencer.sv */
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "reset_seq_consts.svh"

module reset_source_sequencer #(
  parameter int POWERUP_TIMER_CYCLES = `POWERUP_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [7:0]                 haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // configuration and core requests
  input  wire reset_seq_pkg::config_type  cfg,
  input  wire reset_seq_pkg::core_req_type core_req,
  input  wire logic                       sleep_mode,
  // supply monitors
  input  wire logic                       brownout_ready_flag,
  input  wire logic                       supply_low,
  input  wire logic                       low_power_undervolt_detect,
  // external reset pin
  input  wire logic                       external_reset_pin_n,
  // analog controls and outputs
  output logic                            brownout_enable,
  output logic                            bandgap_force_on,
  output logic                            low_power_bor_on,
  output logic                            pin_pullup_on,
  output logic                            pin_gpio_in,
  output logic                            device_reset_n,
  output logic                            core_run
);

  // ==========================================================
  // local wires
  logic [7:0]                 boc_r;
  logic [7:0]                 cause_r;
  logic [1:0]                 stat_r;
  logic                       pullup_sw_r;
  logic                       pin_en;
  logic                       bo_active;
  logic                       bo_trip;
  logic                       pin_low_filt;
  logic                       hard_src;
  logic                       rst_req_n;
  logic [1:0]                 rel_sync_r;
  logic [7:0]                 bo_cnt_r;
  logic [7:0]                 pin_cnt_r;
  logic [31:0]                powerup_timer_cnt_r;
  logic [3:0]                 dly_cnt_r;
  logic                       powerup_timer_done;
  logic                       wake_hold;
  reset_seq_pkg::seq_state_type state_r;
  logic                       ap_valid_r;
  logic                       ap_write_r;
  logic [7:0]                 ap_addr_r;
  logic                       por_event;

  // ==========================================================
  // detector mode decode
  always_comb begin
    unique case (cfg.brownout_mode_sel)
      `BO_MODE_ALWAYS: brownout_enable = 1'b1;
      `BO_MODE_AWAKE:  brownout_enable = ~sleep_mode;
      `BO_MODE_SOFT:   brownout_enable = boc_r[`BOC_SWEN_BIT];
      `BO_MODE_OFF:    brownout_enable = 1'b0;
    endcase
  end

  // fast start only matters in the modes that let the bandgap sleep
  assign bandgap_force_on = boc_r[`BOC_FAST_BIT] &
                            (cfg.brownout_mode_sel == `BO_MODE_AWAKE ||
                             cfg.brownout_mode_sel == `BO_MODE_SOFT);
  assign bo_active        = brownout_enable & brownout_ready_flag;
  assign low_power_bor_on = cfg.low_power_bor_enable;
  assign pin_en           = cfg.ext_reset_pin_enable | cfg.low_voltage_prog_enable;
  assign pin_gpio_in      = external_reset_pin_n;
  assign pin_pullup_on    = pin_en ? 1'b1 : pullup_sw_r;

  // ==========================================================
  // undervoltage filter: brief supply_low dips never reach the reset tree; low-power detector trips pass unfiltered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bo_cnt_r <= 8'h00;
    end else if (!(bo_active && supply_low)) begin
      bo_cnt_r <= 8'h00;
    end else if (bo_cnt_r != 8'(`BOR_FILTER_CYCLES)) begin
      bo_cnt_r <= bo_cnt_r + 8'h01;
    end
  end
  assign bo_trip = (bo_cnt_r == 8'(`BOR_FILTER_CYCLES)) |
                   (cfg.low_power_bor_enable & low_power_undervolt_detect);

  // pin glitch filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_cnt_r <= 8'h00;
    end else if (!(pin_en && !external_reset_pin_n)) begin
      pin_cnt_r <= 8'h00;
    end else if (pin_cnt_r != 8'(`PIN_FILTER_CYCLES)) begin
      pin_cnt_r <= pin_cnt_r + 8'h01;
    end
  end
  assign pin_low_filt = (pin_cnt_r == 8'(`PIN_FILTER_CYCLES));

  // ==========================================================
  // combined reset: async assert, synchronised release
  assign hard_src  = bo_trip | pin_low_filt | core_req.watchdog_timeout | core_req.sw_reset |
                     (cfg.stack_reset_enable & (core_req.stack_overflow | core_req.stack_underflow)) |
                     core_req.prog_mode_exit;
  assign rst_req_n = hresetn & ~hard_src;

  always_ff @(posedge hclk or negedge rst_req_n) begin
    if (!rst_req_n) begin
      rel_sync_r <= 2'b00;
    end else begin
      rel_sync_r <= {rel_sync_r[0], 1'b1};
    end
  end
  assign device_reset_n = rel_sync_r[1];

  // power-up events restart the timer: supply, brown-out, programming exit
  assign por_event = bo_trip | core_req.prog_mode_exit;

  // ==========================================================
  // start-up sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= reset_seq_pkg::SEQ_HOLD;
      powerup_timer_cnt_r <= 32'h0000_0000;
      dly_cnt_r  <= 4'h0;
    end else if (!device_reset_n) begin
      // every reset restarts the start-up walk; only power-up events restart the timer
      state_r <= reset_seq_pkg::SEQ_HOLD;
      if (por_event) begin
        powerup_timer_cnt_r <= 32'h0000_0000;
      end
    end else begin
      // timer counts only while reset is released; a filtered pin low holds it
      if (!powerup_timer_done) begin
        powerup_timer_cnt_r <= powerup_timer_cnt_r + 32'h0000_0001;
      end
      unique case (state_r)
        reset_seq_pkg::SEQ_HOLD: begin
          if (powerup_timer_done) begin
            state_r <= reset_seq_pkg::SEQ_TIMER;
          end
        end
        reset_seq_pkg::SEQ_TIMER: begin
          // mode 11/10 wait for ready; 01 and 00 start at once
          if (!pin_low_filt && (external_reset_pin_n || !pin_en) &&
              (!cfg.brownout_mode_sel[1] || (brownout_ready_flag && !supply_low))) begin
            state_r   <= reset_seq_pkg::SEQ_DELAY;
            dly_cnt_r <= 4'h0;
          end
        end
        reset_seq_pkg::SEQ_DELAY: begin
          if (dly_cnt_r == 4'(`START_DELAY_CYCLES - 1)) begin
            state_r <= reset_seq_pkg::SEQ_RUN;
          end else begin
            dly_cnt_r <= dly_cnt_r + 4'h1;
          end
        end
        reset_seq_pkg::SEQ_RUN: begin
          state_r <= reset_seq_pkg::SEQ_RUN;
        end
      endcase
    end
  end
  assign powerup_timer_done = cfg.powerup_timer_enable_n || (powerup_timer_cnt_r >= POWERUP_TIMER_CYCLES);

  // mode 10 wake-up waits for the detector to come back
  assign wake_hold = (cfg.brownout_mode_sel == `BO_MODE_AWAKE) && !brownout_ready_flag;
  assign core_run  = device_reset_n && (state_r == reset_seq_pkg::SEQ_RUN) && !wake_hold;

  // ==========================================================
  // ahb-lite address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 8'h00;
    end else if (hready) begin
      ap_valid_r <= hsel & htrans[1];
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // control register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boc_r       <= `BOC_RESET_VAL;
      pullup_sw_r <= 1'b1;
    end else if (ap_valid_r && ap_write_r) begin
      if (ap_addr_r == `ADDR_BROWNOUT_CONTROL) begin
        boc_r <= {hwdata[`BOC_SWEN_BIT], hwdata[`BOC_FAST_BIT], 6'h00};
      end
      if (ap_addr_r == `ADDR_PULLUP_CTRL) begin
        pullup_sw_r <= hwdata[0];
      end
    end
  end

  // cause flags: hardware events win over software writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_r <= 8'h1C;
      stat_r  <= 2'b11;
    end else begin
      if (ap_valid_r && ap_write_r && ap_addr_r == `ADDR_RESET_CAUSE) begin
        cause_r <= hwdata[7:0] & `RC_WMASK;
      end
      if (ap_valid_r && ap_write_r && ap_addr_r == `ADDR_STATUS_FLAGS) begin
        stat_r <= hwdata[1:0];
      end
      if (core_req.prog_mode_exit) begin
        cause_r[`RC_POR_BIT] <= 1'b0;
        cause_r[`RC_BOR_BIT] <= 1'b0;
        stat_r               <= 2'b11;
      end
      if (bo_trip) begin
        cause_r[`RC_BOR_BIT] <= 1'b0;
      end
      if (pin_low_filt) begin
        cause_r[`RC_PIN_BIT] <= 1'b0;
      end
      if (core_req.watchdog_timeout) begin
        cause_r[`RC_WDT_BIT] <= 1'b0;
        stat_r[`ST_TIMEOUT_BIT] <= 1'b0;
      end
      if (core_req.sw_reset) begin
        cause_r[`RC_SWRST_BIT] <= 1'b0;
      end
      if (cfg.stack_reset_enable && core_req.stack_overflow) begin
        cause_r[`RC_STACK_OVERFLOW_FLAG_BIT] <= 1'b1;
      end
      if (cfg.stack_reset_enable && core_req.stack_underflow) begin
        cause_r[`RC_STACK_UNDERFLOW_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // read data is a combinational mux of registers plus live bo_active and cfg
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ap_valid_r && !ap_write_r) begin
      unique case (ap_addr_r)
        `ADDR_BROWNOUT_CONTROL: hrdata = {24'h000000, boc_r[7:1], bo_active};
        `ADDR_RESET_CAUSE:      hrdata = {24'h000000, cause_r};
        `ADDR_STATUS_FLAGS:     hrdata = {30'h0, stat_r};
        `ADDR_CONFIG_VIEW:      hrdata = {25'h0, cfg};
        `ADDR_PULLUP_CTRL:      hrdata = {31'h0, pullup_sw_r};
        default:                hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule // reset_source_sequencer

/* shared/reset_seq_consts.svh */
// Function
// - four brown-out modes; off starts immediately
// - mode 11: always on, wait ready
// - mode 11: active in sleep, no wake delay
// - mode 10: on awake, off asleep, wait
// - mode 10: wake waits for detector ready
// - mode 01: software enable, no start wait
// - mode 01: protect when ready, sleep ignored
// - software enable acts only in mode 01
// - fast start forces bandgap in 10/01
// - bit 0 shows detector active
// - low supply filtered by minimum duration
// - low-power detector resets, marks brown-out flag
// - low-power detector enabled by own bit
// - pin reset enabled by lvp or enable
// - pin low holds reset, glitches filtered
// - disabled pin: input, software pull-up
// - watchdog timeout resets, updates timeout/powerdown flags; code clears timeout flag only
// - software reset clears its cause flag
// - stack errors reset when enabled, set flags
// - programming exit behaves as power-on
// - start waits timer and pin release
// - timer independent; 10 cycles after pin; code holds the timer while the pin holds reset
// - power-up timer holds 64 ms
// - timer enabled when active-low bit cleared
// - watchdog, pin, software flags cleared on reset
// - power-on flag cleared, software sets it
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH

// ==========================================================
// register map
`define ADDR_BROWNOUT_CONTROL   8'h00
`define ADDR_RESET_CAUSE        8'h04
`define ADDR_STATUS_FLAGS       8'h08
`define ADDR_CONFIG_VIEW        8'h0C
`define ADDR_PULLUP_CTRL        8'h10

// brown-out control fields
`define BOC_SWEN_BIT            7
`define BOC_FAST_BIT            6
`define BOC_READY_BIT           0
`define BOC_RESET_VAL           8'h80

// reset cause fields
`define RC_STACK_OVERFLOW_FLAG_BIT           7
`define RC_STACK_UNDERFLOW_FLAG_BIT           6
`define RC_WDT_BIT              4
`define RC_PIN_BIT              3
`define RC_SWRST_BIT            2
`define RC_POR_BIT              1
`define RC_BOR_BIT              0
`define RC_WMASK                8'hDF

// status fields
`define ST_TIMEOUT_BIT          1
`define ST_POWERDOWN_BIT        0

// brown-out modes
`define BO_MODE_ALWAYS          2'h3
`define BO_MODE_AWAKE           2'h2
`define BO_MODE_SOFT            2'h1
`define BO_MODE_OFF             2'h0

// timing
`define CLK_MHZ                 50
`define POWERUP_TIMER_MS                 64
`define POWERUP_TIMER_CYCLES             (`POWERUP_TIMER_MS * 1000 * `CLK_MHZ)
`define START_DELAY_CYCLES      10
`define BOR_FILTER_NS           1000
`define BOR_FILTER_CYCLES       ((`BOR_FILTER_NS * `CLK_MHZ + 999) / 1000)
`define PIN_FILTER_NS           200
`define PIN_FILTER_CYCLES       ((`PIN_FILTER_NS * `CLK_MHZ + 999) / 1000)

`endif

/* shared/reset_seq_pkg.sv */
package reset_seq_pkg;

  // configuration word bits seen by the sequencer
  typedef struct packed {
    logic [1:0] brownout_mode_sel;
    logic       low_power_bor_enable;
    logic       ext_reset_pin_enable;
    logic       low_voltage_prog_enable;
    logic       powerup_timer_enable_n;
    logic       stack_reset_enable;
  } config_type;

  // reset requests from the core
  typedef struct packed {
    logic watchdog_timeout;
    logic sw_reset;
    logic stack_overflow;
    logic stack_underflow;
    logic prog_mode_exit;
  } core_req_type;

  typedef enum logic [3:0] {
    SEQ_HOLD  = 4'h1,
    SEQ_TIMER = 4'h2,
    SEQ_DELAY = 4'h4,
    SEQ_RUN   = 4'h8
  } seq_state_type;

endpackage

/* verification/reset_source_sequencer_test.sv */
`timescale 1ns/10ps
module reset_source_sequencer_test;
  localparam int PW = 50;
  // ======================================================
  // bench signals
  logic                        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep_mode = 1'b0;
  logic [7:0]                  haddr = 8'h00;
  logic [1:0]                  htrans = 2'h0;
  logic [31:0]                 hwdata = 32'h0, hrdata, rd, k;
  logic [3:0]                  lag = 4'h3;
  logic                        dip = 1'b0, lp_dip = 1'b0, pin_low = 1'b0, hreadyout, hresp, core_run;
  logic                        brownout_enable, bandgap_force_on, low_power_bor_on, pin_pullup_on, pin_gpio_in;
  logic                        device_reset_n, brownout_ready_flag, supply_low, low_power_undervolt_detect;
  logic                        external_reset_pin_n;
  reset_seq_pkg::config_type   cfg = '0;
  reset_seq_pkg::core_req_type core_req = '0;
  logic [7:0]                  cause_m, st_m;
  int                          failures = 0, check_count = 0, waited, i;
  always #10 hclk = ~hclk;
  reset_source_sequencer #(.POWERUP_TIMER_CYCLES(PW)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cfg, .core_req, .sleep_mode,
    .brownout_ready_flag, .supply_low, .low_power_undervolt_detect, .external_reset_pin_n, .brownout_enable,
    .bandgap_force_on, .low_power_bor_on, .pin_pullup_on, .pin_gpio_in, .device_reset_n, .core_run);
  supply_model u_far (.hclk, .ready_lag(lag), .dip, .lp_dip, .pin_low, .brownout_enable,
    .brownout_ready_flag, .supply_low, .low_power_undervolt_detect, .external_reset_pin_n);
  // ======================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ======================================================
  // bus master: address phase, then data phase; read data taken at its edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    chk("hresp", 0, hresp);
    if (n >= 40) wrap_up;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // bounded wait for execution; the count is kept for timing checks
  task automatic wait_run(input int lim);
    waited = 0;
    while (core_run !== 1'b1 && waited < lim) begin
      @(posedge hclk);
      waited++;
    end
    if (waited >= lim) begin
      chk("timeout", 1, 0);
      wrap_up;
    end
  endtask
  // one-cycle request pulse; bit 4 watchdog down to bit 0 programming exit
  task automatic kick(input int b);
    core_req <= 5'(1 << b);
    @(posedge hclk);
    core_req <= '0;
    repeat (3) @(posedge hclk);
    wait_run(PW * 4);
  endtask
  // ======================================================
  // expectations
  function automatic logic [7:0] nxt_cause(input logic [7:0] c, input int b);
    case (b)
      4: return c & 8'hEF;
      3: return c & 8'hFB;
      2: return c | 8'h80;
      1: return c | 8'h40;
      default: return 8'h1C;
    endcase
  endfunction
  function automatic logic exp_en(input logic [31:0] v);
    case (v[1:0])
      2'h3: return 1'b1;
      2'h2: return !v[2];
      2'h1: return v[4];
      default: return 1'b0;
    endcase
  endfunction
  // ======================================================
  // main sequence
  initial begin
    void'($urandom(32'hAEA8));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(8'h00, 32'h80, "boc");
    rdchk(8'h04, 32'h1C, "cause");
    rdchk(8'h08, 32'h03, "status");
    rdchk(8'h10, 32'h01, "pullup");
    bus(1'b1, 8'h20, 32'hFF);
    rdchk(8'h20, 32'h00, "unmapped");
    wait_run(PW * 4);
    chk("boot", 1, waited >= PW);
    st_m = 8'h03;
    cfg.stack_reset_enable <= 1'b1;
    for (i = 0; i < 9; i++) begin
      k = (i < 5) ? 32'(4 - i) : $urandom % 5;
      cfg.powerup_timer_enable_n <= 1'($urandom);
      bus(1'b1, 8'h04, 32'h1F);
      kick(int'(k));
      cause_m = nxt_cause(8'h1F, int'(k));
      st_m = (k == 0) ? 8'h03 : (k == 4) ? (st_m & 8'hFD) : st_m;
      rdchk(8'h04, cause_m, "cause");
      rdchk(8'h08, st_m, "status");
      if (k == 0) chk("powerup_timer", cfg.powerup_timer_enable_n, waited < PW);
    end
    cfg.stack_reset_enable <= 1'b0;
    cfg.powerup_timer_enable_n <= 1'b0;
    kick(2);
    rdchk(8'h04, cause_m, "stack off");
    cfg.ext_reset_pin_enable <= 1'b1;
    pin_low <= 1'b1;
    repeat (3) @(posedge hclk);
    pin_low <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("glitch", 1, device_reset_n);
    pin_low <= 1'b1;
    repeat (30) @(posedge hclk);
    chk("pin hold", 0, device_reset_n);
    pin_low <= 1'b0;
    wait_run(PW * 4);
    chk("pin start", 1, waited >= 10);
    rdchk(8'h04, cause_m & 8'hF7, "pin cause");
    cfg.brownout_mode_sel <= 2'h3;
    repeat (20) @(posedge hclk);
    dip <= 1'b1;
    repeat (10) @(posedge hclk);
    dip <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("dip short", 1, device_reset_n);
    dip <= 1'b1;
    repeat (70) @(posedge hclk);
    chk("dip long", 0, device_reset_n);
    dip <= 1'b0;
    wait_run(PW * 4);
    chk("bor start", 1, waited >= PW);
    rdchk(8'h04, cause_m & 8'hF6, "bor cause");
    bus(1'b1, 8'h04, 32'h1F);
    cfg.brownout_mode_sel <= 2'h0;
    cfg.low_power_bor_enable <= 1'b1;
    lp_dip <= 1'b1;
    repeat (70) @(posedge hclk);
    chk("lp hold", 0, device_reset_n);
    lp_dip <= 1'b0;
    wait_run(PW * 4);
    rdchk(8'h04, 32'h1E, "lp cause");
    for (i = 0; i < 16; i++) begin
      k = $urandom;
      lag <= k[11:8];
      cfg.brownout_mode_sel <= k[1:0];
      sleep_mode <= k[2];
      cfg.ext_reset_pin_enable <= k[6];
      cfg.low_voltage_prog_enable <= k[7];
      bus(1'b1, 8'h00, {24'h0, k[4:3], 6'h0});
      bus(1'b1, 8'h10, {31'h0, k[5]});
      repeat (20) @(posedge hclk);
      chk("bo_en", exp_en(k), brownout_enable);
      chk("bandgap", k[3] & (k[1] ^ k[0]), bandgap_force_on);
      chk("pullup", k[5] | k[6] | k[7], pin_pullup_on);
      chk("gpio", !pin_low, pin_gpio_in);
      rdchk(8'h00, {24'h0, k[4:3], 5'h0, brownout_ready_flag}, "boc");
    end
    wrap_up;
  end
endmodule // reset_source_sequencer_test

/* verification/seq_monitor.sv */
`timescale 1ns/10ps
module seq_monitor (
  // clock and reset
  input wire logic                        hclk,
  input wire logic                        hresetn,
  // causes seen at the inputs
  input wire reset_seq_pkg::config_type   cfg,
  input wire reset_seq_pkg::core_req_type core_req,
  input wire logic                        sleep_mode,
  input wire logic                        brownout_ready_flag,
  input wire logic                        external_reset_pin_n,
  // outputs under watch
  input wire logic                        brownout_enable,
  input wire logic                        bandgap_force_on,
  input wire logic                        low_power_bor_on,
  input wire logic                        pin_gpio_in,
  input wire logic                        device_reset_n,
  input wire logic                        core_run
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ======================================================
  // sequences
  // an enabled pin held low, long enough to beat any glitch filter
  sequence s_pin_low;
    (cfg.ext_reset_pin_enable || cfg.low_voltage_prog_enable) && !external_reset_pin_n;
  endsequence
  sequence s_pin_long;
    s_pin_low [*8] ##1 s_pin_low [*8];
  endsequence
  // ======================================================
  // properties
  property p_off; cfg.brownout_mode_sel == 2'h0 |-> !brownout_enable; endproperty
  a_off: assert property (p_off) else $error("detector on in off mode");
  property p_always; cfg.brownout_mode_sel == 2'h3 |-> brownout_enable; endproperty
  a_always: assert property (p_always) else $error("detector off in always-on mode");
  property p_awake; cfg.brownout_mode_sel == 2'h2 |-> brownout_enable == !sleep_mode; endproperty
  a_awake: assert property (p_awake) else $error("detector does not follow sleep");
  property p_wake; cfg.brownout_mode_sel == 2'h2 && !brownout_ready_flag |-> !core_run; endproperty
  a_wake: assert property (p_wake) else $error("run before detector ready");
  property p_bandgap; bandgap_force_on |-> ^cfg.brownout_mode_sel; endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap forced in wrong mode");
  property p_lp; low_power_bor_on == cfg.low_power_bor_enable; endproperty
  a_lp: assert property (p_lp) else $error("low-power detector enable wrong");
  property p_gpio; pin_gpio_in == external_reset_pin_n; endproperty
  a_gpio: assert property (p_gpio) else $error("pin function wrong");
  property p_pin_hold; s_pin_long |-> !device_reset_n; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin low but no reset");
  property p_swrst; core_req.sw_reset |-> ##[0:2] !device_reset_n; endproperty
  a_swrst: assert property (p_swrst) else $error("software reset ignored");
  property p_hold_run; !device_reset_n |-> !core_run; endproperty
  a_hold_run: assert property (p_hold_run) else $error("running while in reset");
  property p_start; $rose(core_run) |-> $past(device_reset_n, 8); endproperty
  a_start: assert property (p_start) else $error("run too soon after release");
endmodule // seq_monitor

bind reset_source_sequencer seq_monitor u_mon (.hclk, .hresetn, .cfg, .core_req, .sleep_mode,
  .brownout_ready_flag, .external_reset_pin_n, .brownout_enable, .bandgap_force_on, .low_power_bor_on,
  .pin_gpio_in, .device_reset_n, .core_run);

/* verification/supply_model.sv */
`timescale 1ns/10ps
module supply_model (
  // clock and bench commands
  input wire logic       hclk,
  input wire logic [3:0] ready_lag,
  input wire logic       dip,
  input wire logic       lp_dip,
  input wire logic       pin_low,
  // detector enable from the sequencer
  input wire logic       brownout_enable,
  // monitor outputs and pin level
  output logic           brownout_ready_flag,
  output logic           supply_low,
  output logic           low_power_undervolt_detect,
  output logic           external_reset_pin_n
);
  logic [3:0] warm_r;
  // ======================================================
  // detector warms up for ready_lag cycles; a disabled one is never ready
  always_ff @(posedge hclk) begin
    if (!brownout_enable) warm_r <= 4'h0;
    else if (warm_r != 4'hF) warm_r <= warm_r + 4'h1;
  end
  assign brownout_ready_flag = brownout_enable && (warm_r >= ready_lag);
  // supply follows the bench; the pin is driven as !pin_low, so released reads high
  assign supply_low = dip;
  assign low_power_undervolt_detect = lp_dip;
  assign external_reset_pin_n = !pin_low;
endmodule // supply_model
